// File: design/aes_mutual_auth_sequencer.sv
// symmetric mutual authentication sequencer with wishbone register slave
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "auth_seq_consts.svh"
module aes_mutual_auth_sequencer
  import auth_seq_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output wire logic [31:0]  dat_o,
  output wire logic         ack_o,
  output wire aes_req_t     aes_o,
  input  wire aes_rsp_t     aes_i,
  output wire cmac_req_t    cmac_o,
  input  wire cmac_rsp_t    cmac_i,
  output wire logic         rng_req,
  input  wire rng_rsp_t     rng_i,
  output wire logic [3:0]   key_number,
  output wire logic [255:0] enc_key,
  output wire logic [255:0] mac_key,
  output wire logic         sm_active,
  output wire logic         cmd_ctr_clr,
  output wire logic [31:0]  trans_id
);

  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [127:0] rotl8(input logic [127:0] x);
    return {x[119:0], x[127:120]};
  endfunction

  function automatic logic [255:0] sv(
    input logic [15:0]  lbl,
    input logic [15:0]  ctr,
    input logic [15:0]  len,
    input logic [127:0] a,
    input logic [127:0] b
  );
    return {lbl, ctr, len, a[127:112], a[111:64] ^ b[127:80], b[79:0], a[63:0]};
  endfunction

  // reset release
  logic [1:0] rst_sync_ff;
  wire        rst_n = rst_sync_ff[1];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  state_t        st_ff;
  state_t        nxt_st;
  err_t          err_ff;
  logic          ack_ff;
  logic [31:0]   dat_ff;
  logic [31:0]   cfg_ff;
  logic [27:0]   ucnt_ff;
  logic [27:0]   ulim_ff;
  logic [31:0]   wdto_ff;
  logic [31:0]   wdt_cnt_ff;
  logic          wdt_exp_ff;
  logic [47:0]   rcap_ff;
  logic [31:0]   buf_ff [8];
  logic [127:0]  device_challenge_ff;
  logic [127:0]  reader_challenge_ff;
  logic [127:0]  rbp_ff;
  logic [31:0]   ti_pend_ff;
  logic [31:0]   ti_ff;
  logic [3:0]    pend_key_ff;
  logic          pend_ff;
  logic          pend_next_ff;
  logic          p2_ff;
  logic          nblk_ff;
  logic          blk_ff;
  logic [1:0]    kdf_ff;
  logic          auth_ff;
  logic          clr_ff;
  logic          rng_ff;
  aes_req_t      aes_ff;
  cmac_req_t     cmac_ff;
  logic [255:0]  enc_ff;
  logic [255:0]  mac_ff;

  // bus decode
  wire         bus_req = cyc_i & stb_i & ~ack_ff;
  wire         bus_wr  = bus_req & we_i;
  wire [7:0]   adr     = {adr_i[7:2], 2'b00};
  wire         in_buf  = (adr >= `OFF_BUF) && (adr <= `BUF_LAST);
  wire [2:0]   buf_idx = adr[4:2];
  wire         idle    = st_ff == S_IDLE;
  wire         wr_ctrl = bus_wr && adr == `OFF_CTRL && sel_i[0];
  wire         buf_we  = bus_wr && in_buf && idle;

  wire         cfg_app  = cfg_ff[`CFG_APP];
  wire         cfg_wdt  = cfg_ff[`CFG_WDT];
  wire         cfg_cnt  = cfg_ff[`CFG_CNT];
  wire         cfg_lim  = cfg_ff[`CFG_LIM];
  wire         cfg_256  = cfg_ff[`CFG_256];
  wire         cfg_aes  = cfg_ff[`CFG_AES];
  wire [7:0]   cfg_keys = cfg_ff[`CFG_KEYS];

  wire [127:0] msg_hi = {buf_ff[0], buf_ff[1], buf_ff[2], buf_ff[3]};
  wire [127:0] msg_lo = {buf_ff[4], buf_ff[5], buf_ff[6], buf_ff[7]};

  wire         busy  = ~idle;
  wire         limit_hit = cfg_lim && (ucnt_ff >= ulim_ff);
  wire [31:0]  stat_w = {22'h0, limit_hit, wdt_exp_ff, err_ff, pend_next_ff,
                         pend_ff, auth_ff, busy};
  wire [31:0]  rd_data =
    in_buf                ? buf_ff[buf_idx] :
    (adr == `OFF_STAT)    ? stat_w :
    (adr == `OFF_CFG)     ? cfg_ff :
    (adr == `OFF_UCNT)    ? {4'h0, ucnt_ff} :
    (adr == `OFF_ULIM)    ? {4'h0, ulim_ff} :
    (adr == `OFF_WDTO)    ? wdto_ff :
    (adr == `OFF_RCAPL)   ? rcap_ff[31:0] :
    (adr == `OFF_RCAPH)   ? {16'h0, rcap_ff[47:32]} :
    (adr == `OFF_TID)     ? ti_ff :
    32'h0;

  // command decode
  wire [2:0]   cmd  = dat_i[`CTRL_CMD];
  wire [3:0]   key  = dat_i[`CTRL_KEY];
  wire         len_ok = dat_i[`CTRL_LEN];
  wire         go   = wr_ctrl && idle;
  wire         is_p1 = cmd == C_FIRST1 || cmd == C_NEXT1;
  wire         is_p2 = cmd == C_FIRST2 || cmd == C_NEXT2;
  wire         want_next = cmd == C_NEXT1 || cmd == C_NEXT2;
  // keys 0..4 within an application, existing and of AES type
  wire         key_ok = cfg_app && (key <= `KEY_MAX) && cfg_keys[key[2:0]] && cfg_aes;

  err_t e1;
  err_t e2;
  err_t go_err;
  assign e1 = !len_ok                 ? E_LEN :
              (want_next && !auth_ff) ? E_STATE :
              !key_ok                 ? E_KEY :
              limit_hit               ? E_LIMIT :
              E_OK;
  assign e2 = (!pend_ff || pend_next_ff != want_next) ? E_SEQ :
              wdt_exp_ff              ? E_WDT :
              !len_ok                 ? E_LEN :
              E_OK;
  // a pending attempt tolerates nothing but its own second part
  assign go_err = (pend_ff && !is_p2) ? E_SEQ :
                  is_p1 ? e1 : is_p2 ? e2 : E_OK;

  wire start1 = go && is_p1 && go_err == E_OK;
  wire start2 = go && is_p2 && go_err == E_OK;
  wire fail_go = go && go_err != E_OK;

  // engine events
  wire aes_done  = aes_ff.req & aes_i.ack;
  wire rng_done  = rng_ff & rng_i.ack;
  wire cmac_done = cmac_ff.req & cmac_i.ack;
  wire need2     = (st_ff == S_DEC) || nblk_ff;
  wire last_blk  = blk_ff == need2;
  wire enc_end   = st_ff == S_ENC && aes_done && last_blk;
  wire chk_run   = st_ff == S_CHK;
  wire chk_ok    = chk_run && (rbp_ff == rotl8(device_challenge_ff));
  wire fail_any  = fail_go || (chk_run && !chk_ok);
  wire [1:0] kdf_last = cfg_256 ? 2'h3 : 2'h1;
  wire kdf_end   = st_ff == S_KDF && cmac_done && kdf_ff == kdf_last;
  wire part1_end = enc_end && !p2_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: begin
        if (start1) nxt_st = S_RNGB;
        else if (start2) nxt_st = S_DEC;
      end
      S_RNGB: if (rng_done) nxt_st = pend_next_ff ? S_ENC : S_RNGT;
      S_RNGT: if (rng_done) nxt_st = S_ENC;
      S_ENC:  if (aes_done && last_blk) nxt_st = p2_ff ? S_KDF : S_IDLE;
      S_DEC:  if (aes_done && last_blk) nxt_st = S_CHK;
      S_CHK:  nxt_st = chk_ok ? S_ENC : S_IDLE;
      S_KDF:  if (kdf_end) nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st_ff <= S_IDLE;
    else st_ff <= nxt_st;
  end

  // wishbone answer: one cycle after the request is seen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !we_i) dat_ff <= rd_data;
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff  <= `CFG_RST;
      ulim_ff <= 28'h0;
      wdto_ff <= `WDTO_RST;
      rcap_ff <= 48'h0;
    end else if (bus_wr) begin
      if (adr == `OFF_CFG) cfg_ff <= merge(cfg_ff, dat_i, sel_i);
      if (adr == `OFF_ULIM) ulim_ff <= 28'(merge({4'h0, ulim_ff}, dat_i, sel_i));
      if (adr == `OFF_WDTO) wdto_ff <= merge(wdto_ff, dat_i, sel_i);
      if (adr == `OFF_RCAPL) rcap_ff[31:0] <= merge(rcap_ff[31:0], dat_i, sel_i);
      if (adr == `OFF_RCAPH) rcap_ff[47:32] <= 16'(merge({16'h0, rcap_ff[47:32]}, dat_i, sel_i));
    end
  end

  // message buffer: loaded by software, overwritten by results
  wire [127:0] rnd_ap  = rotl8(reader_challenge_ff);
  wire [127:0] resp_hi = pend_next_ff ? rnd_ap : {ti_pend_ff, rnd_ap[127:32]};
  wire [127:0] resp_lo = {rnd_ap[31:0], `DEV_CAP, rcap_ff};
  wire ld_hi = (st_ff == S_RNGB && rng_done) || (st_ff == S_ENC && aes_done && !blk_ff) || chk_ok;
  wire ld_lo = (st_ff == S_ENC && aes_done && blk_ff) || chk_ok;
  wire [127:0] new_hi = (st_ff == S_RNGB) ? rng_i.data :
                        (st_ff == S_ENC) ? aes_i.dout : resp_hi;
  wire [127:0] new_lo = (st_ff == S_ENC) ? aes_i.dout : resp_lo;
  wire [255:0] new_all = {new_hi, new_lo};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) buf_ff[i] <= 32'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i < 4 ? ld_hi : ld_lo) buf_ff[i] <= new_all[255 - 32*i -: 32];
        else if (buf_we && buf_idx == 3'(i)) buf_ff[i] <= merge(buf_ff[i], dat_i, sel_i);
      end
    end
  end

  // pending attempt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff      <= 1'b0;
      pend_next_ff <= 1'b0;
      pend_key_ff  <= 4'h0;
      device_challenge_ff      <= 128'h0;
      ti_pend_ff   <= 32'h0;
      p2_ff        <= 1'b0;
      nblk_ff      <= 1'b0;
    end else begin
      if (start1) begin
        pend_next_ff <= want_next;
        pend_key_ff  <= key;
        p2_ff        <= 1'b0;
        nblk_ff      <= 1'b0;
      end
      if (start2) p2_ff <= 1'b1;
      if (st_ff == S_RNGB && rng_done) device_challenge_ff <= rng_i.data;
      if (st_ff == S_RNGT && rng_done) ti_pend_ff <= rng_i.data[31:0];
      if (chk_ok) nblk_ff <= ~pend_next_ff;
      if (part1_end) pend_ff <= 1'b1;
      else if (fail_any || start2) pend_ff <= 1'b0;
    end
  end

  // CBC with zero IV over up to two blocks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aes_ff  <= '0;
      blk_ff  <= 1'b0;
      reader_challenge_ff <= 128'h0;
      rbp_ff  <= 128'h0;
    end else begin
      if (aes_done) begin
        aes_ff.req <= 1'b0;
        blk_ff     <= !blk_ff && need2;
      end else if ((st_ff == S_ENC || st_ff == S_DEC) && !aes_ff.req) begin
        aes_ff.req <= 1'b1;
        aes_ff.dec <= st_ff == S_DEC;
        aes_ff.din <= !blk_ff ? msg_hi : (st_ff == S_ENC) ? (msg_lo ^ msg_hi) : msg_lo;
      end
      if (st_ff == S_DEC && aes_done && !blk_ff) reader_challenge_ff <= aes_i.dout;
      if (st_ff == S_DEC && aes_done && blk_ff) rbp_ff <= aes_i.dout ^ msg_hi;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rng_ff <= 1'b0;
    else if (rng_done) rng_ff <= 1'b0;
    else if ((st_ff == S_RNGB || st_ff == S_RNGT) && !rng_ff) rng_ff <= 1'b1;
  end

  // session key derivation
  wire [255:0] kdf_vec = sv(kdf_ff[0] ? `LBL_MAC : `LBL_ENC,
                            kdf_ff[1] ? `CTR_TWO : `CTR_ONE,
                            cfg_256 ? `LEN_256 : `LEN_128,
                            reader_challenge_ff, device_challenge_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmac_ff <= '0;
      kdf_ff  <= 2'h0;
    end else if (cmac_done) begin
      cmac_ff.req <= 1'b0;
      kdf_ff      <= kdf_end ? 2'h0 : kdf_ff + 2'h1;
    end else if (st_ff == S_KDF && !cmac_ff.req) begin
      cmac_ff.req <= 1'b1;
      cmac_ff.msg <= kdf_vec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enc_ff <= 256'h0;
      mac_ff <= 256'h0;
    end else if (chk_ok || fail_any) begin
      enc_ff <= 256'h0;
      mac_ff <= 256'h0;
    end else if (st_ff == S_KDF && cmac_done) begin
      // counter one lands low, counter two shifts it up
      if (kdf_ff[0]) mac_ff <= {mac_ff[127:0], cmac_i.mac};
      else enc_ff <= {enc_ff[127:0], cmac_i.mac};
    end
  end

  // authentication state, identifier and counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      auth_ff <= 1'b0;
      ti_ff   <= 32'h0;
      clr_ff  <= 1'b0;
      err_ff  <= E_OK;
    end else begin
      if (kdf_end) auth_ff <= 1'b1;
      else if (fail_any) auth_ff <= 1'b0;
      if (kdf_end && !pend_next_ff) ti_ff <= ti_pend_ff;
      clr_ff <= part1_end && !pend_next_ff;
      if (go) err_ff <= go_err;
      else if (wr_ctrl) err_ff <= E_BUSY;
      else if (chk_run && !chk_ok) err_ff <= E_MISMATCH;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ucnt_ff <= 28'h0;
    else if (part1_end && !pend_next_ff && cfg_cnt && ucnt_ff != `UCNT_MAX)
      ucnt_ff <= ucnt_ff + 28'h1;
  end

  // watchdog between the two parts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_ff <= 32'h0;
      wdt_exp_ff <= 1'b0;
    end else begin
      if (start1) wdt_cnt_ff <= wdto_ff;
      else if (wdt_cnt_ff != 32'h0) wdt_cnt_ff <= wdt_cnt_ff - 32'h1;
      if (start1) wdt_exp_ff <= 1'b0;
      else if (pend_ff && cfg_wdt && wdt_cnt_ff == 32'h0) wdt_exp_ff <= 1'b1;
    end
  end

  assign dat_o       = dat_ff;
  assign ack_o       = ack_ff;
  assign aes_o       = aes_ff;
  assign cmac_o      = cmac_ff;
  assign rng_req     = rng_ff;
  assign key_number  = pend_key_ff;
  assign enc_key     = enc_ff;
  assign mac_key     = mac_ff;
  assign sm_active   = auth_ff;
  assign cmd_ctr_clr = clr_ff;
  assign trans_id    = ti_ff;

endmodule // aes_mutual_auth_sequencer

// File: design/auth_seq_consts.svh
// register map, field positions and fixed values of the authentication sequencer
// Overview of operation
// - First authentication allowed whether authenticated or not; follow-on only when already authenticated.
// - Any command other than the matching second part aborts a pending attempt.
// - Longer reader messages accepted if length capability is right; reader capabilities not interpreted.
// - Only keys zero to four that exist are usable; others are rejected.
// - Outside an application every symmetric authentication is refused.
// - First part draws a 16-byte challenge, encrypts it, clears counter, makes new identifier.
// - Enabled usage counting adds one per first authentication; reached limit refuses authentication.
// - Usage counter stops at its maximum yet authentications stay accepted.
// - Second part is decrypted and rotated device challenge checked; mismatch refuses.
// - Answer holds rotated reader challenge, identifier, six own and six echoed capability bytes.
// - Watchdog started in first part; expiry before second part refuses the second part.
// - Success derives keys and authenticates; any failure leaves the unauthenticated state.
// - Follow-on refused without active symmetric authentication; only AES keys accepted.
// - Follow-on keeps identifier and counter, no capabilities, no usage count.
// - Session keys come from CMAC counter-mode derivation keyed with the authentication key.
// - Derivation input begins with a two-byte purpose label, one per key.
// - Block counter one, or one to two for 256-bit; length field 128 or 256.
// - Context mixes reader and device challenges into 26 bytes in a fixed order.
// - For 128-bit keys each session key is one CMAC of its vector.
// - For 256-bit keys each session key joins CMACs for counters one and two.
// - Challenge encryption and decryption use AES in CBC mode.
`ifndef AUTH_SEQ_CONSTS_SVH
`define AUTH_SEQ_CONSTS_SVH
`define OFF_CTRL  8'h00
`define OFF_STAT  8'h04
`define OFF_CFG   8'h08
`define OFF_UCNT  8'h0c
`define OFF_ULIM  8'h10
`define OFF_WDTO  8'h14
`define OFF_RCAPL 8'h18
`define OFF_RCAPH 8'h1c
`define OFF_TID   8'h20
`define OFF_BUF   8'h40
`define BUF_LAST  8'h5c
`define CTRL_CMD  2:0
`define CTRL_KEY  7:4
`define CTRL_LEN  8
`define CFG_APP   0
`define CFG_WDT   1
`define CFG_CNT   2
`define CFG_LIM   3
`define CFG_256   4
`define CFG_AES   5
`define CFG_KEYS  15:8
`define CFG_RST   32'h0000_0000
`define WDTO_RST  32'h0000_1000
`define KEY_MAX   4'h4
`define UCNT_MAX  28'hfffffff
`define LBL_MAC   16'h5aa5
`define LBL_ENC   16'ha55a
`define CTR_ONE   16'h0001
`define CTR_TWO   16'h0002
`define LEN_128   16'h0080
`define LEN_256   16'h0100
`define DEV_CAP   48'h0000_0000_0000
`endif

// File: design/auth_seq_pkg.sv
// types shared by the authentication sequencer
package auth_seq_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RNGB = 4'h1, S_RNGT = 4'h3, S_ENC = 4'h2,
    S_DEC = 4'h6, S_CHK = 4'h7, S_KDF = 4'h5
  } state_t;
  typedef enum logic [2:0] {
    C_NONE = 3'h0, C_FIRST1 = 3'h1, C_FIRST2 = 3'h2, C_NEXT1 = 3'h3, C_NEXT2 = 3'h4
  } cmd_t;
  typedef enum logic [3:0] {
    E_OK = 4'h0, E_STATE = 4'h1, E_KEY = 4'h2, E_LIMIT = 4'h3, E_SEQ = 4'h4,
    E_WDT = 4'h5, E_MISMATCH = 4'h6, E_LEN = 4'h7, E_BUSY = 4'h8
  } err_t;
  typedef struct packed {logic req; logic dec; logic [127:0] din;} aes_req_t;
  typedef struct packed {logic ack; logic [127:0] dout;} aes_rsp_t;
  typedef struct packed {logic req; logic [255:0] msg;} cmac_req_t;
  typedef struct packed {logic ack; logic [127:0] mac;} cmac_rsp_t;
  typedef struct packed {logic ack; logic [127:0] data;} rng_rsp_t;
endpackage

// File: verification/auth_seq_sva.sv
// port checker for the authentication sequencer
`timescale 1ns/1ns
module auth_seq_sva
  import auth_seq_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire aes_req_t    aes_o,
  input wire aes_rsp_t    aes_i,
  input wire cmac_req_t   cmac_o,
  input wire cmac_rsp_t   cmac_i,
  input wire logic        rng_req,
  input wire rng_rsp_t    rng_i,
  input wire logic        cmd_ctr_clr,
  input wire logic        sm_active,
  input wire logic [31:0] trans_id
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("bus ack longer than one cycle");
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered in one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("bus ack without request");
  aes_hold_a: assert property (aes_o.req && !aes_i.ack |=> aes_o.req && $stable(aes_o.din))
    else $error("cipher request changed before answer");
  aes_drop_a: assert property (aes_o.req && aes_i.ack |=> !aes_o.req)
    else $error("cipher request kept after answer");
  cmac_hold_a: assert property (cmac_o.req && !cmac_i.ack |=> cmac_o.req && $stable(cmac_o.msg))
    else $error("derivation request changed before answer");
  rng_hold_a: assert property (rng_req && !rng_i.ack |=> rng_req)
    else $error("random request dropped early");
  engine_excl_a: assert property ($onehot0({rng_req, aes_o.req, cmac_o.req}))
    else $error("two engine requests at once");
  clr_pulse_a: assert property (cmd_ctr_clr |=> !cmd_ctr_clr)
    else $error("counter clear not a single pulse");
  ti_commit_a: assert property ($changed(trans_id) |-> ##[0:2] sm_active)
    else $error("identifier changed without authentication");
  cover property ($rose(sm_active));
  cover property (cmd_ctr_clr);
  cover property (cmac_o.req && cmac_i.ack);
endmodule  // auth_seq_sva
bind aes_mutual_auth_sequencer auth_seq_sva u_sva (
  .clk_sys(clk_sys), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .aes_o(aes_o), .aes_i(aes_i), .cmac_o(cmac_o), .cmac_i(cmac_i), .rng_req(rng_req),
  .rng_i(rng_i), .cmd_ctr_clr(cmd_ctr_clr), .sm_active(sm_active), .trans_id(trans_id));

// File: verification/crypto_engine_model.sv
// behavioural aes, cmac and random engines that answer the sequencer
`timescale 1ns/1ns
module crypto_engine_model
  import auth_seq_pkg::*;
#(
  parameter logic [127:0] KC = 128'h0
)(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire aes_req_t   aes_o,
  output aes_rsp_t        aes_i,
  input  wire cmac_req_t  cmac_o,
  output cmac_rsp_t       cmac_i,
  input  wire logic       rng_req,
  output rng_rsp_t        rng_i,
  output logic [127:0]    rng_prev,
  output logic [127:0]    rng_last
);
  logic [1:0]   cnt_ff;
  logic [127:0] seed_ff;
  // answers come after one to four cycles; data lines toggle while idle
  wire          go_aes  = aes_o.req && !aes_i.ack && cnt_ff == 2'h0;
  wire          go_cmac = cmac_o.req && !cmac_i.ack && cnt_ff == 2'h0;
  wire          go_rng  = rng_req && !rng_i.ack && cnt_ff == 2'h0;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 2'h0;
      seed_ff <= 128'h3c5a_9e01_77d2_b4f8_0a6e_c319_5d24_8bf6;
      aes_i <= '0;
      cmac_i <= '0;
      rng_i <= '0;
      rng_prev <= '0;
      rng_last <= '0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      aes_i.ack <= go_aes;
      aes_i.dout <= go_aes ? aes_o.din ^ KC : ~aes_i.dout;
      cmac_i.ack <= go_cmac;
      cmac_i.mac <= go_cmac ? cmac_o.msg[255:128] ^ cmac_o.msg[127:0] ^ KC : ~cmac_i.mac;
      rng_i.ack <= go_rng;
      rng_i.data <= go_rng ? seed_ff : ~rng_i.data;
      if (go_rng) begin
        seed_ff <= seed_ff + 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;
        rng_prev <= rng_last;
        rng_last <= seed_ff;
      end
    end
  end
endmodule  // crypto_engine_model

// File: verification/tb.sv
// self-checking bench for the authentication sequencer
`timescale 1ns/1ns
`include "auth_seq_consts.svh"
module tb;
  import auth_seq_pkg::*;
  localparam logic [127:0] KC = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
  logic           clk_sys, nrst, cyc_i, stb_i, we_i;
  logic [7:0]     adr_i;
  logic [31:0]    dat_i, dat_o, trans_id;
  logic           ack_o, rng_req, sm_active, cmd_ctr_clr;
  logic [3:0]     key_number;
  logic [255:0]   enc_key, mac_key;
  logic [127:0]   rng_prev, rng_last;
  aes_req_t       aes_o;
  aes_rsp_t       aes_i;
  cmac_req_t      cmac_o;
  cmac_rsp_t      cmac_i;
  rng_rsp_t       rng_i;
  int             n_mismatch, checks_done, nclr;
  aes_mutual_auth_sequencer DUT (.clk_sys(clk_sys), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .aes_o(aes_o), .aes_i(aes_i), .cmac_o(cmac_o), .cmac_i(cmac_i), .rng_req(rng_req),
    .rng_i(rng_i), .key_number(key_number), .enc_key(enc_key), .mac_key(mac_key),
    .sm_active(sm_active), .cmd_ctr_clr(cmd_ctr_clr), .trans_id(trans_id));
  crypto_engine_model #(.KC(KC)) mdl (.clk_sys(clk_sys), .nrst(nrst), .aes_o(aes_o),
    .aes_i(aes_i), .cmac_o(cmac_o), .cmac_i(cmac_i), .rng_req(rng_req), .rng_i(rng_i),
    .rng_prev(rng_prev), .rng_last(rng_last));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (cmd_ctr_clr === 1'b1) nclr++;
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [127:0] rotl(input logic [127:0] x);
    return {x[119:0], x[127:120]};
  endfunction
  function automatic logic [127:0] kdf(input logic [15:0] l, c, n, input logic [127:0] a, b);
    logic [255:0] sv;
    sv = {l, c, n, a[127:112], a[111:64] ^ b[127:80], b[79:0], a[63:0]};
    return sv[255:128] ^ sv[127:0] ^ KC;
  endfunction
  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 100) n_mismatch++;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic run(input logic [2:0] c, input logic [3:0] k, output logic [31:0] st);
    int n;
    wr(`OFF_CTRL, {23'h0, 1'b1, k, 1'b0, c});
    n = 0;
    do begin
      rd(`OFF_STAT, st);
      n++;
    end while (st[0] !== 1'b0 && n < 300);
    if (n >= 300) n_mismatch++;
  endtask
  task automatic rdbuf(input int w0, output logic [127:0] b);
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      rd(8'(`OFF_BUF + 4 * (w0 + i)), q);
      b[127 - 32 * i -: 32] = q;
    end
  endtask
  // reader side: cbc with zero iv over the joined challenges
  task automatic send(input logic [2:0] c, input logic [127:0] ra, rbr, output logic [31:0] st);
    logic [255:0] m;
    m = {ra ^ KC, rbr ^ ra};
    for (int i = 0; i < 8; i++) wr(8'(`OFF_BUF + 4 * i), m[255 - 32 * i -: 32]);
    run(c, 4'h2, st);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    rd(`OFF_CFG, q);
    chk(q, `CFG_RST);
    rd(`OFF_WDTO, q);
    chk(q, `WDTO_RST);
    rd(8'h30, q);
    chk(q, 0);
    chk(sm_active, 0);
  endtask
  task automatic t_refuse();
    logic [31:0] st;
    wr(`OFF_CFG, 32'h0000_1f20);
    run(C_FIRST1, 4'h0, st);
    chk({st[2], sm_active, st[7:4] == E_OK}, 0);
    wr(`OFF_CFG, 32'h0000_1b21);
    run(C_FIRST1, 4'h2, st);
    chk(st[7:4], E_KEY);
    wr(`OFF_CFG, 32'h0000_1f21);
    run(C_NEXT1, 4'h2, st);
    chk(st[7:4], E_STATE);
    for (int k = 5; k < 8; k++) begin
      run(C_FIRST1, 4'(k), st);
      chk(st[7:4], E_KEY);
    end
  endtask
  task automatic t_first(output logic [31:0] ti);
    logic [31:0] st, q;
    logic [127:0] b, rb, ra, rar;
    int n0;
    ra = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    rar = rotl(ra);
    wr(`OFF_CFG, 32'h0000_1f25);
    wr(`OFF_RCAPL, 32'h1234_5678);
    wr(`OFF_RCAPH, 32'h0000_c0de);
    n0 = nclr;
    run(C_FIRST1, 4'h2, st);
    chk({st[2], key_number, nclr - n0}, {1'b1, 4'h2, 32'd1});
    rd(`OFF_UCNT, q);
    chk(q, 1);
    rdbuf(0, b);
    rb = b ^ KC;
    chk(rb, rng_prev);
    ti = rng_last[31:0];
    send(C_FIRST2, ra, rotl(rb), st);
    chk({st[7:4], sm_active, trans_id}, {E_OK, 1'b1, ti});
    rdbuf(0, b);
    chk(b, {ti, rar[127:32]} ^ KC);
    rdbuf(4, b);
    chk(b, {rar[31:0], `DEV_CAP, 48'hc0de_1234_5678} ^ {ti, rar[127:32]});
    chk(enc_key[127:0], kdf(`LBL_ENC, `CTR_ONE, `LEN_128, ra, rb));
    chk(mac_key[127:0], kdf(`LBL_MAC, `CTR_ONE, `LEN_128, ra, rb));
  endtask
  task automatic t_next(input logic [31:0] ti);
    logic [31:0] st, q;
    logic [127:0] b, ra;
    int n0;
    ra = 128'hfeed_0001_beef_0002_cafe_0003_face_0004;
    n0 = nclr;
    run(C_NEXT1, 4'h2, st);
    rd(`OFF_UCNT, q);
    chk({q, nclr - n0}, {32'd1, 32'd0});
    rdbuf(0, b);
    chk(b ^ KC, rng_last);
    send(C_NEXT2, ra, rotl(b ^ KC), st);
    chk({st[7:4], sm_active, trans_id}, {E_OK, 1'b1, ti});
    rdbuf(0, b);
    chk(b, rotl(ra) ^ KC);
  endtask
  task automatic t_fail();
    logic [31:0] st, q;
    logic [127:0] b;
    run(C_FIRST1, 4'h2, st);
    chk(st[2], 1);
    run(3'h5, 4'h2, st);
    chk({st[7:4], st[2], sm_active}, {E_SEQ, 2'b00});
    run(C_FIRST1, 4'h2, st);
    rdbuf(0, b);
    send(C_FIRST2, 128'h5, b ^ KC, st);
    chk({st[7:4], sm_active}, {E_MISMATCH, 1'b0});
    wr(`OFF_CFG, 32'h0000_1f27);
    wr(`OFF_WDTO, 32'h0000_0010);
    run(C_FIRST1, 4'h2, st);
    repeat (40) @(posedge clk_sys);
    rdbuf(0, b);
    send(C_FIRST2, 128'h5, rotl(b ^ KC), st);
    chk({st[7:4], sm_active}, {E_WDT, 1'b0});
    rd(`OFF_UCNT, q);
    chk(q, 4);
    wr(`OFF_CFG, 32'h0000_1f2f);
    wr(`OFF_ULIM, q);
    run(C_FIRST1, 4'h2, st);
    chk(st[7:4], E_LIMIT);
  endtask
  task automatic t_wide();
    logic [31:0] st;
    logic [127:0] b;
    wr(`OFF_CFG, 32'h0000_1f31);
    run(C_FIRST1, 4'h2, st);
    rdbuf(0, b);
    b = b ^ KC;
    send(C_FIRST2, 128'h9, rotl(b), st);
    chk(enc_key, {kdf(`LBL_ENC, `CTR_ONE, `LEN_256, 128'h9, b),
                  kdf(`LBL_ENC, `CTR_TWO, `LEN_256, 128'h9, b)});
    chk(mac_key, {kdf(`LBL_MAC, `CTR_ONE, `LEN_256, 128'h9, b),
                  kdf(`LBL_MAC, `CTR_TWO, `LEN_256, 128'h9, b)});
  endtask
  initial begin
    logic [31:0] ti;
    {nrst, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_refuse();
    t_first(ti);
    t_next(ti);
    t_fail();
    t_wide();
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule  // tb
